//--- stdp_pkg.sv
// Shared constants for the single tap pulse detector
package stdp_pkg;
    // ========================================================
    // Widths and reset values
    localparam int          STDP_SAMPLE_W = 12;
    localparam int          STDP_TLIM_W   = 8;
    localparam int          STDP_AXES     = 3;
    localparam logic [11:0] STDP_RST_THR  = 12'h000;
    localparam logic [7:0]  STDP_RST_TLIM = 8'h00;
    localparam logic        STDP_RST_FLAG = 1'b0;

    // ========================================================
    // Per-axis pulse tracker states
    typedef enum logic [1:0]
    {
        STDP_IDLE = 2'b00,
        STDP_HIGH = 2'b01,
        STDP_OVER = 2'b10
    } stdp_state_t;
endpackage : stdp_pkg

//--- stdp_axis_if.sv
// Signals between the top and one axis tracker
`timescale 1ns/1ns
interface stdp_axis_if #(parameter int W = 12, parameter int TW = 8);
    logic                valid;
    logic signed [W-1:0] raw;
    logic signed [W-1:0] hpf;
    logic                skip;
    logic                lpf;
    logic        [W-1:0] thr;
    logic       [TW-1:0] lim;
    logic                tap;
    logic                pol;

    modport axis (input valid, raw, hpf, skip, lpf, thr, lim, output tap, pol);
    modport top  (output valid, raw, hpf, skip, lpf, thr, lim, input tap, pol);
endinterface : stdp_axis_if

//--- stdp_axis.sv
// Pulse tracker for one axis: source select, low-pass, threshold, duration limit
`timescale 1ns/1ns
module stdp_axis
    import stdp_pkg::*;
#(
    parameter int W  = STDP_SAMPLE_W,
    parameter int TW = STDP_TLIM_W
)
(
    input wire logic   ref_clk,
    input wire logic   nrst,
    stdp_axis_if.axis  ax
);
    // ========================================================
    // Sample path
    function automatic logic [W-1:0] stdp_abs(input logic signed [W-1:0] v);
        stdp_abs = v[W-1] ? W'(-v) : W'(v);
    endfunction : stdp_abs

    logic signed [W-1:0] lp;
    stdp_state_t         state;
    logic       [TW-1:0] cnt;

    wire logic signed [W-1:0] src     = ax.skip ? ax.raw : ax.hpf;          // [R6]
    wire logic signed [W:0]   diff    = {src[W-1], src} - {lp[W-1], lp};
    // Halving the step keeps the filter free of multipliers; corner near 1/9 of the rate
    wire logic signed [W-1:0] next_lp = W'(lp + diff[W:1]);
    wire logic signed [W-1:0] filt    = ax.lpf ? next_lp : src;             // [R5]
    wire logic        [W-1:0] mag     = stdp_abs(filt);
    wire logic                above   = (mag >= ax.thr);                    // [R13]
    wire logic                accept  = (cnt <= ax.lim);                    // [R12]

    // ========================================================
    // Tracker
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lp     <= '0;
            state  <= STDP_IDLE;
            cnt    <= '0;
            ax.tap <= 1'b0;
            ax.pol <= 1'b0;
        end
        else
        begin
            ax.tap <= 1'b0;
            if (ax.valid)
            begin
                lp <= next_lp;
                case (state)
                    STDP_IDLE:
                        if (above)
                        begin
                            state  <= STDP_HIGH;
                            cnt    <= TW'(1);
                            ax.pol <= filt[W-1];
                        end
                    STDP_HIGH:
                        if (!above)
                        begin
                            state  <= STDP_IDLE;
                            ax.tap <= accept;                                // [R12]
                        end
                        else if (cnt >= ax.lim)
                            state <= STDP_OVER;                              // [R12]
                        else
                            cnt <= cnt + 1'b1;
                    STDP_OVER:
                        if (!above)
                            state <= STDP_IDLE;
                    default:
                        state <= STDP_IDLE;
                endcase
            end
        end
    end

    // ========================================================
    // Checks
    sequence s_too_long;
        ax.valid && state == STDP_HIGH && above && cnt >= ax.lim;
    endsequence

    AST_OVER_NO_TAP: assert property (@(posedge ref_clk) disable iff (!nrst) // [R12]
        s_too_long |=> state == STDP_OVER && !ax.tap)
        else $error("over-long pulse not rejected");

    AST_BELOW_IGNORED: assert property (@(posedge ref_clk) disable iff (!nrst) // [R13]
        ax.valid && state == STDP_IDLE && !above |=> state == STDP_IDLE && !ax.tap)
        else $error("sub-threshold sample started a pulse");

    AST_TAP_CAUSE: assert property (@(posedge ref_clk) disable iff (!nrst) // [R12]
        ax.tap |-> $past(state) == STDP_HIGH && $past(ax.valid) && !$past(above))
        else $error("tap without a finished pulse");
endmodule : stdp_axis

//--- stdp_top.sv
// Single tap detector: standby-gated configuration, axis trackers, status and interrupt
// ========================================================
// How it works
// R1 - Configuration loads only while standby; loads during active mode are dropped.
// R2 - Host enters standby before changing settings, then returns to active.
// R3 - Host single-tap preset writes factory values into every single-tap setting.
// R4 - Host single-plus-double preset writes factory values into the thresholds.
// R5 - Optional low-pass filter on samples suppresses very fast shocks.
// R6 - Skip option feeds raw samples instead of high-pass samples.
// R7 - Host should keep the skip option off to avoid tilt false taps.
// R8 - Per-axis enables; only enabled axes raise the event indication.
// R9 - Latch mode holds event and status until the status read clears them; the read leaves axis_negative as it is.
// R10 - Without latch the interrupt lasts only as long as the event.
// R11 - Without latch status shows only the most recent event.
// R12 - Pulses lasting longer than the time limit are not taps.
// R13 - Per-axis threshold; smaller pulses on that axis are ignored.
// R14 - Event flag on any enabled tap, plus per-axis flags and polarity.
`timescale 1ns/1ns
module stdp_top
    import stdp_pkg::*;
#(
    parameter int W  = STDP_SAMPLE_W,
    parameter int TW = STDP_TLIM_W
)
(
    input  wire logic          ref_clk,
    input  wire logic          nrst,
    input  wire logic          active,
    input  wire logic          cfg_load,
    input  wire logic          x_single_pulse_en,
    input  wire logic          y_single_pulse_en,
    input  wire logic          z_single_pulse_en,
    input  wire logic          latch_en,
    input  wire logic          lowpass_tap_en,
    input  wire logic          highpass_skip,
    input  wire logic [TW-1:0] pulse_time_limit,
    input  wire logic [W-1:0]  x_threshold,
    input  wire logic [W-1:0]  y_threshold,
    input  wire logic [W-1:0]  z_threshold,
    input  wire logic          sample_valid,
    input  wire logic [W-1:0]  raw_x,
    input  wire logic [W-1:0]  raw_y,
    input  wire logic [W-1:0]  raw_z,
    input  wire logic [W-1:0]  hpf_x,
    input  wire logic [W-1:0]  hpf_y,
    input  wire logic [W-1:0]  hpf_z,
    input  wire logic          status_read,
    output logic               event_detected,
    output logic [2:0]         axis_detected,
    output logic [2:0]         axis_negative,
    output logic               tap_irq
);
    // Reset constants are sized for the documented widths only
    generate
        if (W < 2 || W != STDP_SAMPLE_W || TW != STDP_TLIM_W)
        begin : g_bad_width
            $error("stdp_top: unsupported widths");
        end
    endgenerate

    // ========================================================
    // Configuration, frozen while active
    logic [2:0]    cfg_en;
    logic          cfg_latch;
    logic          cfg_lpf;
    logic          cfg_skip;
    logic [TW-1:0] cfg_lim;
    logic [W-1:0]  cfg_thr [STDP_AXES];

    // A load tried while active is dropped, not deferred to the next standby
    wire logic cfg_take = cfg_load && !active;                               // [R1]

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_en     <= {3{STDP_RST_FLAG}};
            cfg_latch  <= STDP_RST_FLAG;
            cfg_lpf    <= STDP_RST_FLAG;
            cfg_skip   <= STDP_RST_FLAG;
            cfg_lim    <= STDP_RST_TLIM;
            cfg_thr[0] <= STDP_RST_THR;
            cfg_thr[1] <= STDP_RST_THR;
            cfg_thr[2] <= STDP_RST_THR;
        end
        else if (cfg_take)                                                   // [R1]
        begin
            cfg_en     <= {z_single_pulse_en, y_single_pulse_en, x_single_pulse_en};
            cfg_latch  <= latch_en;
            cfg_lpf    <= lowpass_tap_en;
            cfg_skip   <= highpass_skip;
            cfg_lim    <= pulse_time_limit;
            cfg_thr[0] <= x_threshold;
            cfg_thr[1] <= y_threshold;
            cfg_thr[2] <= z_threshold;
        end
    end

    // ========================================================
    // Axis trackers
    wire logic [W-1:0] raw_all [STDP_AXES] = '{raw_x, raw_y, raw_z};
    wire logic [W-1:0] hpf_all [STDP_AXES] = '{hpf_x, hpf_y, hpf_z};
    logic [2:0] taps;
    logic [2:0] tap_pol;

    // Every tracker shares the sample strobe and the frozen filter, skip and limit settings; each takes its own threshold
    genvar gi;
    generate
        for (gi = 0; gi < STDP_AXES; gi++)
        begin : g_axis
            stdp_axis_if #(.W(W), .TW(TW)) axif ();
            assign axif.valid  = sample_valid;
            assign axif.raw    = raw_all[gi];
            assign axif.hpf    = hpf_all[gi];
            assign axif.skip   = cfg_skip;
            assign axif.lpf    = cfg_lpf;
            assign axif.thr    = cfg_thr[gi];
            assign axif.lim    = cfg_lim;
            assign taps[gi]    = axif.tap;
            assign tap_pol[gi] = axif.pol;
            stdp_axis #(.W(W), .TW(TW)) u_axis
            (
                .ref_clk (ref_clk),
                .nrst    (nrst),
                .ax      (axif.axis)
            );
        end
    endgenerate

    // ========================================================
    // Status and interrupt
    wire logic [2:0] hit = taps & cfg_en;                                    // [R8]
    wire logic       any = |hit;                                             // [R14]
    wire logic       clr = status_read && cfg_latch;                         // [R9]
    // In latch mode a new tap in the read cycle survives the clear
    wire logic [2:0] next_det_latch = (axis_detected & ~{3{clr}}) | hit;     // [R9]
    wire logic       next_evt_latch = (event_detected && !clr) || any;       // [R9]
    wire logic [2:0] next_det  = cfg_latch ? next_det_latch : (any ? hit : axis_detected); // [R11]
    wire logic       next_evt  = cfg_latch ? next_evt_latch : (any || event_detected);     // [R11]
    // Latch mode keeps the polarity of axes that saw no new tap
    wire logic [2:0] next_neg  = (axis_negative & ~hit) | (tap_pol & hit);   // [R14]
    wire logic       next_irq  = cfg_latch ? next_evt_latch : any;           // [R10]

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            event_detected <= STDP_RST_FLAG;
            axis_detected  <= {3{STDP_RST_FLAG}};
            axis_negative  <= {3{STDP_RST_FLAG}};
            tap_irq        <= STDP_RST_FLAG;
        end
        else
        begin
            event_detected <= next_evt;
            axis_detected  <= next_det;
            axis_negative  <= (!cfg_latch && any) ? (tap_pol & hit) : next_neg;
            tap_irq        <= next_irq;
        end
    end

    // ========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_latched_evt;
        cfg_latch && event_detected;
    endsequence

    sequence s_cfg_write;
        cfg_load && !active;
    endsequence

    AST_CFG_FROZEN: assert property (active |=> $stable(cfg_lim) && $stable(cfg_en) // [R1]
        && $stable(cfg_latch) && $stable(cfg_thr[0]))
        else $error("configuration changed while active");
    AST_DISABLED_AXIS: assert property ((taps & ~cfg_en) != 3'h0 && !any && !cfg_latch // [R8]
        |=> !tap_irq)
        else $error("disabled axis raised the interrupt");
    AST_LATCH_HOLD: assert property ((s_latched_evt and !status_read) |=> event_detected && tap_irq) // [R9]
        else $error("latched event dropped without a read");
    AST_LATCH_CLEAR: assert property (s_latched_evt ##0 (status_read && !any) |=> !event_detected // [R9]
        && axis_detected == 3'h0)
        else $error("status read did not clear latched event");
    AST_FOLLOW_IRQ: assert property (!cfg_latch |=> tap_irq == $past(any)) // [R10]
        else $error("unlatched interrupt outlived its event");
    AST_MOST_RECENT: assert property (!cfg_latch && any |=> axis_detected == $past(hit)) // [R11]
        else $error("status not overwritten by newest event");
    AST_EVENT_SET: assert property (any |=> event_detected && tap_irq // [R14]
        && (axis_detected & $past(hit)) == $past(hit))
        else $error("enabled tap did not raise the event");
    AST_POLARITY: assert property (hit[0] |=> axis_negative[0] == $past(tap_pol[0])) // [R14]
        else $error("tap polarity not recorded");

    AST_CFG_TAKEN: assert property (s_cfg_write |=> cfg_lim == $past(pulse_time_limit) // [R1]
        && cfg_en == $past({z_single_pulse_en, y_single_pulse_en, x_single_pulse_en})
        && cfg_latch == $past(latch_en) && cfg_thr[2] == $past(z_threshold))
        else $error("standby load not captured");
    // In latch mode the interrupt is the latched event itself
    AST_LATCH_IRQ: assert property (cfg_latch |=> tap_irq == event_detected) // [R9]
        else $error("latched interrupt differs from event");
    AST_NEG_KEEP: assert property (cfg_latch |=> (axis_negative & ~$past(hit)) // [R14]
        == ($past(axis_negative) & ~$past(hit)))
        else $error("polarity of an axis without a tap changed");
    // Without latch the event flag is sticky; only the axis bits follow the newest tap
    AST_NOLATCH_STICKY: assert property (!cfg_latch && event_detected |=> event_detected) // [R11]
        else $error("unlatched event flag dropped");
    AST_NOLATCH_KEEP: assert property (!cfg_latch && !any |=> $stable(axis_detected) // [R11]
        && $stable(axis_negative))
        else $error("status changed without a new tap");

    generate
        for (gi = 0; gi < STDP_AXES; gi++)
        begin : g_pol_chk
            AST_POL_AXIS: assert property (hit[gi] |=> axis_negative[gi] == $past(tap_pol[gi])) // [R14]
                else $error("axis polarity not recorded");
        end
    endgenerate
endmodule : stdp_top

//--- stdp_host.sv
// Host-side model: standby-gated configuration, presets and status reads
`timescale 1ns/1ns
module stdp_host
    import stdp_pkg::*;
#(
    parameter logic [7:0]  DEF_LIM = 8'h04,
    parameter logic [11:0] DEF_THR = 12'h080
)
(
    input  wire logic   ref_clk,
    output logic        active,
    output logic        cfg_load,
    output logic [2:0]  en,
    output logic        latch_en,
    output logic        lpf,
    output logic        skip,
    output logic [7:0]  lim,
    output logic [35:0] thr,
    output logic        status_read
);
    initial {active, cfg_load, en, latch_en, lpf, skip, lim, thr, status_read} = '0;

    // Standby around every load, back to active after
    task automatic setup(input logic [2:0] e, input logic l, p, s, input logic [7:0] t, input logic [35:0] th);
        @(posedge ref_clk);
        #1 active = 1'b0;
        cfg_load = 1'b1;
        {en, latch_en, lpf, skip, lim, thr} = {e, l, p, s, t, th};
        @(posedge ref_clk);
        #1 cfg_load = 1'b0;
        active = 1'b1;
    endtask : setup

    task automatic preset_single();
        setup(3'b111, 1'b0, 1'b0, 1'b0, DEF_LIM, {3{DEF_THR}});
    endtask : preset_single

    // Thresholds only; other settings are kept as they are
    task automatic preset_sd();
        setup(en, latch_en, lpf, skip, lim, {3{DEF_THR}});
    endtask : preset_sd

    // A load tried in active mode, which the device must ignore
    task automatic load_active(input logic [2:0] e);
        @(posedge ref_clk);
        #1 cfg_load = 1'b1;
        en = e;
        @(posedge ref_clk);
        #1 cfg_load = 1'b0;
    endtask : load_active

    task automatic rd();
        @(posedge ref_clk);
        #1 status_read = 1'b1;
        @(posedge ref_clk);
        #1 status_read = 1'b0;
    endtask : rd
endmodule : stdp_host

//--- test_single_tap_pulse_detector.sv
// Self-checking bench for the single tap detector
`timescale 1ns/1ns
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) \
    begin failures++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module test_single_tap_pulse_detector
    import stdp_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        sample_valid = 1'b0;
    logic [35:0] r = '0;
    logic [35:0] h = '0;
    logic        active, cfg_load, latch_en, lpf, skip, status_read;
    logic [2:0]  en, axis_detected, axis_negative;
    logic [7:0]  lim;
    logic [35:0] thr;
    logic        event_detected, tap_irq;
    int          failures = 0;
    int          compares = 0;
    int          cycles = 0;

    always #20 ref_clk = ~ref_clk;

    stdp_host u_host (.ref_clk(ref_clk), .active(active), .cfg_load(cfg_load), .en(en), .latch_en(latch_en),
        .lpf(lpf), .skip(skip), .lim(lim), .thr(thr), .status_read(status_read));

    stdp_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .active(active), .cfg_load(cfg_load),
        .x_single_pulse_en(en[0]), .y_single_pulse_en(en[1]), .z_single_pulse_en(en[2]),
        .latch_en(latch_en), .lowpass_tap_en(lpf), .highpass_skip(skip), .pulse_time_limit(lim),
        .x_threshold(thr[11:0]), .y_threshold(thr[23:12]), .z_threshold(thr[35:24]),
        .sample_valid(sample_valid), .raw_x(r[11:0]), .raw_y(r[23:12]), .raw_z(r[35:24]),
        .hpf_x(h[11:0]), .hpf_y(h[23:12]), .hpf_z(h[35:24]), .status_read(status_read),
        .event_detected(event_detected), .axis_detected(axis_detected),
        .axis_negative(axis_negative), .tap_irq(tap_irq));

    task automatic finish_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    // Ceiling well above the hundred or so cycles the tests need
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            finish_test();
        end
    end

    // ========================================================
    // Sample helpers
    task automatic smp(input logic [35:0] rv, hv);
        @(posedge ref_clk);
        #1 sample_valid = 1'b1;
        r = rv;
        h = hv;
        @(posedge ref_clk);
        #1 sample_valid = 1'b0;
    endtask : smp

    // n loud samples, one quiet one, then wait until the outputs have landed
    task automatic tap(input logic [35:0] rv, hv, input int n);
        repeat (n) smp(rv, hv);
        smp('0, '0);
        @(posedge ref_clk);
        #1;
    endtask : tap

    // ========================================================
    // Scenarios
    task automatic t_latch();
        u_host.setup(3'b001, 1'b1, 1'b0, 1'b0, 8'h02, {3{12'h064}});
        tap('0, 36'h0000000c8, 2);
        `CHK("axis", 3'b001, axis_detected)
        `CHK("irq", 1'b1, tap_irq)
        repeat (3) @(posedge ref_clk);
        #1 `CHK("held", 2'b11, {event_detected, tap_irq})
        u_host.rd();
        `CHK("cleared", 5'h00, {event_detected, axis_detected, tap_irq})
        $display("t_latch done");
    endtask : t_latch

    task automatic t_axes();
        u_host.setup(3'b110, 1'b1, 1'b0, 1'b0, 8'h02, {3{12'h064}});
        tap('0, {12'h0c8, 12'hf38, 12'hf38}, 1);
        `CHK("axis", 3'b110, axis_detected)
        `CHK("neg", 3'b010, axis_negative)
        u_host.rd();
        $display("t_axes done");
    endtask : t_axes

    task automatic t_limit();
        u_host.setup(3'b001, 1'b1, 1'b0, 1'b0, 8'h02, {3{12'h064}});
        tap('0, 36'h0000000c8, 3);
        `CHK("event", 1'b0, event_detected)
        $display("t_limit done");
    endtask : t_limit

    task automatic t_thr();
        u_host.setup(3'b111, 1'b1, 1'b0, 1'b0, 8'h02, {12'h0c8, 12'h12c, 12'h064});
        tap('0, {12'h0c7, 12'h12b, 12'h064}, 1);
        `CHK("axis", 3'b001, axis_detected)
        u_host.rd();
        $display("t_thr done");
    endtask : t_thr

    task automatic t_lpf();
        u_host.setup(3'b001, 1'b1, 1'b1, 1'b0, 8'h02, {3{12'h096}});
        tap('0, 36'h0000000c8, 1);
        `CHK("event", 1'b0, event_detected)
        $display("t_lpf done");
    endtask : t_lpf

    task automatic t_skip();
        u_host.setup(3'b001, 1'b1, 1'b0, 1'b0, 8'h02, {3{12'h064}});
        tap(36'h0000000c8, '0, 1);
        `CHK("event", 1'b0, event_detected)
        u_host.setup(3'b001, 1'b1, 1'b0, 1'b1, 8'h02, {3{12'h064}});
        tap(36'h0000000c8, '0, 1);
        `CHK("event", 1'b1, event_detected)
        u_host.rd();
        $display("t_skip done");
    endtask : t_skip

    task automatic t_active();
        u_host.setup(3'b001, 1'b1, 1'b0, 1'b0, 8'h02, {3{12'h064}});
        u_host.load_active(3'b000);
        tap('0, 36'h0000000c8, 1);
        `CHK("event", 1'b1, event_detected)
        u_host.rd();
        $display("t_active done");
    endtask : t_active

    // Last, since the event flag stays high once set without latching
    task automatic t_nolatch();
        u_host.preset_single();
        u_host.preset_sd();
        tap('0, 36'h0000000c8, 1);
        `CHK("axis", 3'b001, axis_detected)
        `CHK("irq", 1'b1, tap_irq)
        @(posedge ref_clk);
        #1 `CHK("irq", 1'b0, tap_irq)
        tap('0, 36'h000f38000, 1);
        `CHK("axis", 3'b010, axis_detected)
        `CHK("neg", 3'b010, axis_negative)
        // A tap on a disabled axis must leave status and interrupt alone
        u_host.setup(3'b001, 1'b0, 1'b0, 1'b0, 8'h04, {3{12'h080}});
        tap('0, 36'h0c8000000, 1);
        `CHK("axis", 3'b010, axis_detected)
        `CHK("irq", 1'b0, tap_irq)
        u_host.rd();
        `CHK("axis", 3'b010, axis_detected)
        $display("t_nolatch done");
    endtask : t_nolatch

    initial
    begin
        repeat (3) @(posedge ref_clk);
        #1 nrst = 1'b1;
        `CHK("reset", 8'h00, {event_detected, axis_detected, axis_negative, tap_irq})
        t_latch();
        t_axes();
        t_limit();
        t_thr();
        t_lpf();
        t_skip();
        t_active();
        t_nolatch();
        finish_test();
    end
endmodule : test_single_tap_pulse_detector
